// File: swm_pkg.sv
// Constants for the single-wire bus master: command codes, op codes and slot timing.
// Assumes a 100 MHz system clock; all cycle counts are derived from the times below.
package swm_pkg;
  localparam int unsigned CLK_NS = 10;
  // Host operations.
  typedef enum logic [1:0] {SWM_OP_RESET, SWM_OP_WRITE, SWM_OP_READ} swm_op_type;
  // Bus states.
  typedef enum logic [2:0] {SWM_IDLE, SWM_RST_LOW, SWM_RST_HIGH, SWM_SLOT_LOW,
                            SWM_SLOT_REST} swm_state_type;
  localparam logic [7:0] CMD_OD_SKIP = 8'h3C;
  localparam logic [7:0] CMD_OD_MATCH = 8'h69;
  localparam int unsigned BYTE_BITS = 8;
  // Times in ns, standard speed then overdrive speed.
  localparam int unsigned RST_LOW_STD_NS = 480000;
  localparam int unsigned RST_LOW_OD_NS = 70000;
  localparam int unsigned RST_HIGH_STD_NS = 480000;
  localparam int unsigned RST_HIGH_OD_NS = 48000;
  localparam int unsigned PSMP_STD_NS = 70000;
  localparam int unsigned PSMP_OD_NS = 8000;
  localparam int unsigned W0_STD_NS = 60000;
  localparam int unsigned W0_OD_NS = 7000;
  localparam int unsigned W1_STD_NS = 6000;
  localparam int unsigned W1_OD_NS = 1000;
  localparam int unsigned RL_STD_NS = 6000;
  localparam int unsigned RL_OD_NS = 1000;
  localparam int unsigned MSR_STD_NS = 14000;
  localparam int unsigned MSR_OD_NS = 2000;
  localparam int unsigned SLOT_STD_NS = 70000;
  localparam int unsigned SLOT_OD_NS = 10000;
  // Least times round up to whole cycles; sample points are longest times and round down.
  localparam int unsigned RST_LOW_STD_CYC = (RST_LOW_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RST_LOW_OD_CYC = (RST_LOW_OD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RST_HIGH_STD_CYC = (RST_HIGH_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RST_HIGH_OD_CYC = (RST_HIGH_OD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PSMP_STD_CYC = PSMP_STD_NS / CLK_NS;
  localparam int unsigned PSMP_OD_CYC = PSMP_OD_NS / CLK_NS;
  localparam int unsigned W0_STD_CYC = (W0_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned W0_OD_CYC = (W0_OD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned W1_STD_CYC = W1_STD_NS / CLK_NS;
  localparam int unsigned W1_OD_CYC = W1_OD_NS / CLK_NS;
  localparam int unsigned RL_STD_CYC = (RL_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RL_OD_CYC = (RL_OD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned MSR_STD_CYC = MSR_STD_NS / CLK_NS;
  localparam int unsigned MSR_OD_CYC = MSR_OD_NS / CLK_NS;
  localparam int unsigned SLOT_STD_CYC = (SLOT_STD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SLOT_OD_CYC = (SLOT_OD_NS + CLK_NS - 1) / CLK_NS;
endpackage

// File: swm_buf_if.sv
// Valid/ready carrier between the bus engine and its answer buffer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface swm_buf_if #(parameter int unsigned WIDTH = 9);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  modport fill (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
  modport store (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

// File: swm_pair_buf.sv
// Small answer buffer, two entries by default, between the bus engine and the user.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module swm_pair_buf #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Both sides of the buffer.
  swm_buf_if.store bif
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("swm_pair_buf: DEPTH must be a power of two of at least 2");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill_cnt;
  logic push;
  logic pop;

  // Full and empty come straight from the fill count, so the producer sees real back-pressure.
  assign bif.in_ready = (fill_cnt != (AW+1)'(DEPTH));
  assign bif.out_valid = (fill_cnt != '0);
  assign bif.out_data = mem[rd_ptr];
  assign push = bif.in_valid && bif.in_ready;
  assign pop = bif.out_valid && bif.out_ready;

  // Storage is written only; it needs no reset because empty entries are never shown.
  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr] <= bif.in_data;
    end
  end

  // Pointers and fill level.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill_cnt <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      fill_cnt <= fill_cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// File: swm_master.sv
// Single-wire bus master: reset/presence, write slots and read slots, byte at a time.
// Assumes an open-drain line with an external pullup and one clock of 100 MHz.
//
// Overview of operation
// - First byte after presence is the ROM command.
// - Master leaves line high while suspended.
// - Overdrive timing holds until a long reset.
// - After broadcast skip, reset at overdrive speed.
// - Master samples presence at the sample time.
// - Reset high window covers presence and recovery.
// - Mixed buses: long reset high window.
// - Each slot carries exactly one bit.
// - Write one: line released before its limit.
// - Write zero: line held low long enough.
// - Allow recovery before the next slot.
// - Read slot: brief low, then release.
// - Sample read inside window, then finish slot.
`timescale 1ns/1ns
`default_nettype none
module swm_master #(
  parameter int unsigned RST_LOW_STD = swm_pkg::RST_LOW_STD_CYC,
  parameter int unsigned RST_HIGH_STD = swm_pkg::RST_HIGH_STD_CYC,
  parameter int unsigned PSMP_STD = swm_pkg::PSMP_STD_CYC,
  parameter int unsigned W0_STD = swm_pkg::W0_STD_CYC,
  parameter int unsigned SLOT_STD = swm_pkg::SLOT_STD_CYC
) (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Command port.
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [1:0] cmd_op_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_long_i,
  // Answer port.
  output logic rsp_valid_o,
  input wire logic rsp_ready_i,
  output logic [7:0] rsp_data_o,
  output logic rsp_reset_o,
  // Status.
  output logic overdrive_o,
  output logic busy_o,
  // Bus line.
  input wire logic line_i,
  output logic line_o,
  output logic line_oe_o
);
  initial begin
    if (RST_LOW_STD >= 65536 || RST_HIGH_STD >= 65536 || SLOT_STD >= 65536
        || PSMP_STD >= RST_HIGH_STD || W0_STD >= SLOT_STD || W0_STD < 1) begin
      $error("swm_master: timing parameters do not fit the 16-bit slot timer");
    end
  end

  swm_buf_if #(.WIDTH(9)) bif ();
  swm_pair_buf #(.WIDTH(9), .DEPTH(2)) u_buf (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .bif(bif)
  );

  swm_pkg::swm_state_type state;
  logic [15:0] cnt;
  logic [2:0] bit_idx;
  logic [7:0] shift;
  logic [7:0] wbyte;
  logic is_read;
  logic long_rst;
  logic od;
  logic rom_phase;
  logic samp;
  logic sync1;
  logic sync2;
  logic sync3;
  logic line_s;
  logic push_valid;
  logic [8:0] push_data;
  logic [15:0] t_rst_low;
  logic [15:0] t_rst_high;
  logic [15:0] t_psmp;
  logic [15:0] t_low;
  logic [15:0] t_msr;
  logic [15:0] t_slot;
  logic accept;
  logic slot_end;

  // Every waveform follows the current speed, reset and presence included.
  // A long reset at overdrive must really be long, or the device keeps its speed.
  assign t_rst_low = (od && !long_rst) ? 16'(swm_pkg::RST_LOW_OD_CYC) : 16'(RST_LOW_STD);
  assign t_rst_high = od ? 16'(swm_pkg::RST_HIGH_OD_CYC) : 16'(RST_HIGH_STD);
  assign t_psmp = od ? 16'(swm_pkg::PSMP_OD_CYC) : 16'(PSMP_STD);
  assign t_msr = od ? 16'(swm_pkg::MSR_OD_CYC) : 16'(swm_pkg::MSR_STD_CYC);
  assign t_slot = od ? 16'(swm_pkg::SLOT_OD_CYC) : 16'(SLOT_STD);

  // Low phase length: short for a read or a one, long for a zero.
  always_comb begin
    if (is_read) begin
      t_low = od ? 16'(swm_pkg::RL_OD_CYC) : 16'(swm_pkg::RL_STD_CYC);
    end else if (shift[0]) begin
      t_low = od ? 16'(swm_pkg::W1_OD_CYC) : 16'(swm_pkg::W1_STD_CYC);
    end else begin
      t_low = od ? 16'(swm_pkg::W0_OD_CYC) : 16'(W0_STD);
    end
  end

  // A command needing an answer waits until the buffer has room; an answer still being pushed in that cycle is not counted, so one can be dropped.
  assign cmd_ready_o = (state == swm_pkg::SWM_IDLE)
                       && (cmd_op_i == 2'(swm_pkg::SWM_OP_WRITE) || bif.in_ready);
  assign accept = cmd_valid_i && cmd_ready_o;
  // The slot also waits for the line to be seen high, giving the device its recovery.
  assign slot_end = (state == swm_pkg::SWM_SLOT_REST) && (cnt >= t_slot - 16'h0001) && line_s;
  // Idle drives nothing, so a suspended transfer leaves the line high.
  assign line_oe_o = (state == swm_pkg::SWM_RST_LOW) || (state == swm_pkg::SWM_SLOT_LOW);
  assign line_o = 1'b0;
  assign busy_o = (state != swm_pkg::SWM_IDLE);
  assign overdrive_o = od;
  assign bif.in_valid = push_valid;
  assign bif.in_data = push_data;
  assign bif.out_ready = rsp_ready_i;
  assign rsp_valid_o = bif.out_valid;
  assign rsp_data_o = bif.out_data[7:0];
  assign rsp_reset_o = bif.out_data[8];

  // Line synchroniser; a change is taken only once the last two stages agree.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      line_s <= 1'b1;
    end else begin
      sync1 <= line_i;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        line_s <= sync3;
      end
    end
  end

  // Sequencer for reset pulses and bit slots; one slot moves one bit.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= swm_pkg::SWM_IDLE;
      cnt <= 16'h0000;
      bit_idx <= 3'h0;
      shift <= 8'h00;
      wbyte <= 8'h00;
      is_read <= 1'b0;
      long_rst <= 1'b1;
    end else begin
      unique case (state)
        swm_pkg::SWM_IDLE: begin
          cnt <= 16'h0000;
          bit_idx <= 3'h0;
          if (accept) begin
            is_read <= (cmd_op_i == 2'(swm_pkg::SWM_OP_READ));
            shift <= (cmd_op_i == 2'(swm_pkg::SWM_OP_WRITE)) ? cmd_data_i : 8'hFF;
            wbyte <= cmd_data_i;
            // At overdrive the user may ask for a short reset to stay fast.
            long_rst <= !od || cmd_long_i;
            if (cmd_op_i == 2'(swm_pkg::SWM_OP_RESET)) begin
              state <= swm_pkg::SWM_RST_LOW;
            end else begin
              state <= swm_pkg::SWM_SLOT_LOW;
            end
          end
        end
        swm_pkg::SWM_RST_LOW: begin
          cnt <= cnt + 16'h0001;
          if (cnt >= t_rst_low - 16'h0001) begin
            cnt <= 16'h0000;
            state <= swm_pkg::SWM_RST_HIGH;
          end
        end
        swm_pkg::SWM_RST_HIGH: begin
          cnt <= cnt + 16'h0001;
          // The device is ready for slots as soon as this window ends.
          if (cnt >= t_rst_high - 16'h0001) begin
            state <= swm_pkg::SWM_IDLE;
          end
        end
        swm_pkg::SWM_SLOT_LOW: begin
          cnt <= cnt + 16'h0001;
          if (cnt >= t_low - 16'h0001) begin
            state <= swm_pkg::SWM_SLOT_REST;
          end
        end
        swm_pkg::SWM_SLOT_REST: begin
          if (!slot_end) begin
            cnt <= cnt + 16'h0001;
          end else begin
            cnt <= 16'h0000;
            // Shift right so the next bit out and the next bit in are both bit 0 first.
            shift <= {is_read ? samp : 1'b1, shift[7:1]};
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'(swm_pkg::BYTE_BITS - 1)) begin
              state <= swm_pkg::SWM_IDLE;
            end else begin
              state <= swm_pkg::SWM_SLOT_LOW;
            end
          end
        end
        default: begin
          state <= swm_pkg::SWM_IDLE;
        end
      endcase
    end
  end

  // Presence sampled at the fixed point; read bit sampled at the latest point of the window.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      samp <= 1'b1;
    end else if (state == swm_pkg::SWM_RST_HIGH && cnt == t_psmp - 16'h0001) begin
      samp <= !line_s;
    end else if (state == swm_pkg::SWM_SLOT_REST && is_read && cnt == t_msr - 16'h0001) begin
      samp <= line_s;
    end
  end

  // Overdrive tracking: set by an overdrive ROM command, cleared by a long reset only.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      od <= 1'b0;
      rom_phase <= 1'b0;
    end else if (state == swm_pkg::SWM_RST_LOW && cnt >= t_rst_low - 16'h0001) begin
      rom_phase <= 1'b1;
      if (long_rst) begin
        od <= 1'b0;
      end
    end else if (slot_end && bit_idx == 3'(swm_pkg::BYTE_BITS - 1)) begin
      rom_phase <= 1'b0;
      // Match code bytes that follow go out at overdrive speed.
      if (!is_read && rom_phase && (wbyte == swm_pkg::CMD_OD_SKIP
                                    || wbyte == swm_pkg::CMD_OD_MATCH)) begin
        od <= 1'b1;
      end
    end
  end

  // Answer pushes: presence after each reset, data after each read byte.
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      push_valid <= 1'b0;
      push_data <= 9'h000;
    end else begin
      push_valid <= 1'b0;
      if (state == swm_pkg::SWM_RST_HIGH && cnt >= t_rst_high - 16'h0001) begin
        push_valid <= 1'b1;
        push_data <= {1'b1, 7'h00, samp};
      end else if (slot_end && is_read && bit_idx == 3'(swm_pkg::BYTE_BITS - 1)) begin
        push_valid <= 1'b1;
        push_data <= {1'b0, samp, shift[7:1]};
      end
    end
  end

  // Checks on the line waveform, the speed flag, one bit per slot, bit order and presence sampling.
  chk_zero_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state == swm_pkg::SWM_SLOT_LOW && !is_read && !shift[0] && cnt < t_low - 16'h0001
    |=> line_oe_o)
    else $error("write zero released too early");
  chk_one_release: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $rose(line_oe_o) && state == swm_pkg::SWM_SLOT_LOW && !is_read && shift[0] && !od
    |-> ##[1:600] !line_oe_o)
    else $error("write one held low too long");
  chk_read_low: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state == swm_pkg::SWM_SLOT_LOW && is_read
    |-> line_oe_o && cnt < (od ? 16'(swm_pkg::RL_OD_CYC) : 16'(swm_pkg::RL_STD_CYC)))
    else $error("read slot low phase wrong");
  chk_od_set: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    slot_end && rom_phase && !is_read && bit_idx == 3'h7 && wbyte == swm_pkg::CMD_OD_SKIP
    |=> od)
    else $error("overdrive skip did not set speed");
  chk_od_long_clr: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state == swm_pkg::SWM_RST_LOW && long_rst && cnt >= t_rst_low - 16'h0001 |=> !od)
    else $error("long reset left overdrive set");
  chk_od_short_keep: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state == swm_pkg::SWM_RST_LOW && !long_rst |=> od)
    else $error("short reset dropped overdrive");
  chk_one_bit_slot: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    slot_end |=> bit_idx == $past(bit_idx) + 3'h1)
    else $error("slot did not advance one bit");
  chk_slot_spacing: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state == swm_pkg::SWM_SLOT_REST ##1 state == swm_pkg::SWM_SLOT_LOW
    |-> $past(cnt) >= t_slot - 16'h0001 && $past(line_s))
    else $error("next slot started before recovery");
  chk_lsb_first: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    accept && cmd_op_i == 2'(swm_pkg::SWM_OP_WRITE) |=> shift[0] == $past(cmd_data_i[0]))
    else $error("first bit is not bit 0");
  chk_presence_pt: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    state == swm_pkg::SWM_RST_HIGH && cnt == t_psmp - 16'h0001 |=> samp == !$past(line_s))
    else $error("presence not sampled at its point");
endmodule
`default_nettype wire

// File: swm_dev_model.sv
// Behavioural slave on the single-wire bus: presence, write and read slots, ROM layer.
// Assumes the bench resolves the open-drain wire with a pull-up and feeds it back here.
`timescale 1ns/1ns
`default_nettype none
module swm_dev_model #(
  parameter logic [63:0] ROM_CODE = 64'h5A3C_0F96_1E87_4B2D, // Arbitrary value.
  parameter logic [7:0] MEM_BYTE = 8'hA6,
  parameter int unsigned RST_DET = 3000,
  parameter int unsigned OD_CLR = 8000
) (
  // Wire level.
  input wire logic line_i,
  // High while the model pulls the line low.
  output logic pull_o
);
  typedef enum logic [1:0] {SWD_ROM, SWD_CODE, SWD_MEM, SWD_IDLE} swm_dev_phase_type;
  swm_dev_phase_type phase;
  logic od;
  logic od_prev;
  logic rc;
  logic b;
  logic [7:0] cmd;
  logic [63:0] code;
  int unsigned nbit;
  longint unsigned low;
  time t0;

  // One pass per falling edge; the low length in 10 ns cycles tells a reset from a slot.
  // Timing is behavioural, so the line's sampling never races the clocked master.
  initial begin
    pull_o = 1'b0;
    od = 1'b0;
    od_prev = 1'b0;
    rc = 1'b0;
    b = 1'b0;
    cmd = 8'h00;
    code = 64'h0;
    nbit = 0;
    phase = SWD_IDLE;
    forever begin
      @(negedge line_i);
      t0 = $time;
      if (phase == SWD_MEM && !MEM_BYTE[nbit]) begin
        b = 1'b0;
        pull_o = 1'b1;
        #(od ? 3500 : 16000);
        pull_o = 1'b0;
      end else begin
        #(od ? 3000 : 8000);
        b = line_i;
      end
      if (line_i !== 1'b1) @(posedge line_i);
      low = ($time - t0) / 10;
      if (low >= RST_DET) begin
        if (low > OD_CLR) od = 1'b0;
        #(od ? 200 : 1500);
        pull_o = 1'b1;
        #(od ? 10000 : 15000);
        pull_o = 1'b0;
        phase = SWD_ROM;
        nbit = 0;
      end else begin
        case (phase)
          SWD_ROM: begin
            cmd = {b, cmd[7:1]};
            nbit = nbit + 1;
            if (nbit == 8) begin
              nbit = 0;
              od_prev = od;
              phase = SWD_IDLE;
              if (cmd == 8'h55 || cmd == 8'h69 || cmd == 8'h3C) rc = 1'b0;
              if (cmd == 8'h69 || cmd == 8'h3C) od = 1'b1;
              if (cmd == 8'h55 || cmd == 8'h69) phase = SWD_CODE;
              if (cmd == 8'h3C || (cmd == 8'hA5 && rc)) phase = SWD_MEM;
            end
          end
          SWD_CODE: begin
            code = {b, code[63:1]};
            nbit = nbit + 1;
            if (nbit == 64) begin
              nbit = 0;
              rc = (code == ROM_CODE);
              phase = (code == ROM_CODE) ? SWD_MEM : SWD_IDLE;
              if (code != ROM_CODE) od = od_prev;
            end
          end
          SWD_MEM: nbit = (nbit + 1) % 8;
          default: nbit = 0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench: bus master against the behavioural slave, standard counts shortened.
// Assumes the package, carrier, buffer, master and slave model are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int unsigned RST_LOW = 10000;
  localparam int unsigned LIMIT = 200000;
  localparam logic [63:0] CODE = 64'h5A3C_0F96_1E87_4B2D; // Arbitrary value, as in the model.
  localparam logic [7:0] MEM = 8'hA6;
  logic mclk;
  logic rst_b;
  logic cmd_valid;
  logic cmd_ready;
  logic [1:0] cmd_op;
  logic [7:0] cmd_data;
  logic cmd_long;
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_data;
  logic rsp_reset;
  logic overdrive;
  logic busy;
  logic line_o;
  logic line_oe;
  logic dev_pull;
  wire bus_line;
  int unsigned error_cnt = 0;
  int unsigned total_checks = 0;
  int unsigned run_len = 0;
  int unsigned last_low = 0;

  // Open-drain wire with pull-up: low when either party pulls.
  assign bus_line = (line_oe ? line_o : 1'b1) & ~dev_pull;

  swm_master #(.RST_LOW_STD(RST_LOW), .RST_HIGH_STD(3000), .PSMP_STD(1000), .W0_STD(1000),
    .SLOT_STD(2000)) swm_master_i (.mclk_i(mclk), .rst_b_i(rst_b), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op), .cmd_data_i(cmd_data), .cmd_long_i(cmd_long),
    .rsp_valid_o(rsp_valid), .rsp_ready_i(rsp_ready), .rsp_data_o(rsp_data),
    .rsp_reset_o(rsp_reset), .overdrive_o(overdrive), .busy_o(busy), .line_i(bus_line),
    .line_o(line_o), .line_oe_o(line_oe));
  swm_dev_model #(.ROM_CODE(CODE), .MEM_BYTE(MEM)) swm_dev_model_i (.line_i(bus_line),
    .pull_o(dev_pull));

  // Clock of 100 MHz.
  always #5 mclk = ~mclk;

  // Length of the master's last low pulse, so speed can be judged from the wire.
  always @(posedge mclk) begin
    if (line_oe === 1'b1) run_len <= run_len + 1;
    else begin
      if (run_len != 0) last_low <= run_len;
      run_len <= 0;
    end
  end

  task automatic end_sim();
    $display("checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected byte at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected flag at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait, kind 0 for ready, 1 for an answer, 2 for idle; a hang ends the run.
  task automatic wait_on(input int unsigned kind);
    int unsigned n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      if (n > LIMIT) begin
        error_cnt++;
        $display("unexpected hang at %0t: kind %h, limit %h", $time, kind, LIMIT);
        end_sim();
      end
    end while (!((kind == 0 && cmd_ready === 1'b1) || (kind == 1 && rsp_valid === 1'b1) ||
      (kind == 2 && busy === 1'b0)));
  endtask

  // Request held until taken at a rising edge, then the bench waits for the op to end.
  task automatic issue(input logic [1:0] op, input logic [7:0] data, input logic lng);
    @(posedge mclk);
    #1;
    cmd_op = op;
    cmd_data = data;
    cmd_long = lng;
    cmd_valid = 1'b1;
    wait_on(0);
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    wait_on(2);
  endtask

  task automatic pop(input logic [7:0] exp, input logic exp_rst);
    wait_on(1);
    check_byte(rsp_data, exp);
    check_bit(rsp_reset, exp_rst);
    @(posedge mclk);
    #1;
    rsp_ready = 1'b1;
    @(posedge mclk);
    #1;
    rsp_ready = 1'b0;
  endtask

  task automatic t_reset_values();
    check_bit(busy, 1'b0);
    check_bit(overdrive, 1'b0);
    check_bit(line_oe, 1'b0);
    issue(swm_pkg::SWM_OP_RESET, 8'h00, 1'b1);
    pop(8'h01, 1'b1);
    check_bit(last_low >= RST_LOW, 1'b1);
  endtask

  task automatic t_od_skip();
    issue(swm_pkg::SWM_OP_WRITE, 8'h3C, 1'b0);
    check_bit(overdrive, 1'b1);
    issue(swm_pkg::SWM_OP_READ, 8'h00, 1'b0);
    pop(MEM, 1'b0);
    check_bit(last_low < 200, 1'b1);
  endtask

  // Match at overdrive, then fill the answer buffer until a read is refused.
  task automatic t_od_match();
    issue(swm_pkg::SWM_OP_RESET, 8'h00, 1'b0);
    pop(8'h01, 1'b1);
    check_bit(overdrive, 1'b1);
    check_bit(last_low < 8000, 1'b1);
    issue(swm_pkg::SWM_OP_WRITE, 8'h69, 1'b0);
    for (int i = 0; i < 8; i++) issue(swm_pkg::SWM_OP_WRITE, CODE[8*i +: 8], 1'b0);
    issue(swm_pkg::SWM_OP_READ, 8'h00, 1'b0);
    issue(swm_pkg::SWM_OP_READ, 8'h00, 1'b0);
    @(posedge mclk);
    #1;
    cmd_op = swm_pkg::SWM_OP_READ;
    cmd_valid = 1'b1;
    repeat (3) @(negedge mclk);
    check_bit(cmd_ready, 1'b0);
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    pop(MEM, 1'b0);
    pop(MEM, 1'b0);
  endtask

  task automatic t_resume();
    issue(swm_pkg::SWM_OP_RESET, 8'h00, 1'b0);
    pop(8'h01, 1'b1);
    issue(swm_pkg::SWM_OP_WRITE, 8'hA5, 1'b0);
    issue(swm_pkg::SWM_OP_READ, 8'h00, 1'b0);
    pop(MEM, 1'b0);
  endtask

  task automatic t_long_reset();
    issue(swm_pkg::SWM_OP_RESET, 8'h00, 1'b1);
    pop(8'h01, 1'b1);
    check_bit(overdrive, 1'b0);
    check_bit(last_low > 8000, 1'b1);
  endtask

  // Main sequence: reset held for ten cycles, then each scenario in turn.
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 2'h0;
    cmd_data = 8'h00;
    cmd_long = 1'b0;
    rsp_ready = 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    t_reset_values();
    t_od_skip();
    t_od_match();
    t_resume();
    t_long_reset();
    end_sim();
  end
endmodule
`default_nettype wire
